/* File: src/tpmpwm_top.sv */
/*
 * Three-phase motor PWM generator: Wishbone register file, prescaler,
 * sawtooth/triangle counter, duty compare, dead time and polarity.
 * Assumes classic Wishbone on clk_i and asynchronous event pins for
 * position detection and the two timers.
 */
// How it works
// - Single-side generation only allowed while control B bit 7 is set.
// - Control B bit 2 set turns off lower outputs of PWM-selected phases, non-complementary; fixed levels are kept.
// - Counter clock is source clock divided by 1, 2, 4 or 8.
// - Half-period bit with interval 00 raises event every half period.
// - Control A bit 6 clear: all phases use U duty; set: own duty.
// - Upper outputs active low when polarity bit clear, high when set.
// - Lower outputs active low when polarity bit clear, high when set.
// - Event interval field gives one event per 1, 2, 4 or 8 periods.
// - Alignment bit clear sawtooth, set triangular counting.
// - Control A bit 0 enables synthesis; clear holds outputs inactive.
// - Dead time is setting times two source clocks between complementary edges.
// - Output control bit 15 reads counter direction, 1 counting down.
// - Bits 14..12 hold writable W, V, U position comparison pattern.
// - Bit 11 set applies new settings at period, clear immediately.
// - Phase select bits 10..8: fixed level when clear, PWM when set.
// - Output update source: immediate, position detect, timer 1, timer 2.
// - Counter value readable as twelve-bit read-only register.
// - Duty bit 15 selects single-side PWM for that phase.
// - Each phase has a writable twelve-bit duty value.
`timescale 1ns/1ps
module tpmpwm_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [13:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Output update events from outside
   input  wire logic        pos_detect_i,
   input  wire logic        timer1_i,
   input  wire logic        timer2_i,
   // Gate drive and status
   output logic      [2:0]  upper_o,
   output logic      [2:0]  lower_o,
   output logic      [2:0]  pos_pattern_o,
   output logic             pwm_event_o
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_a;
   logic [7:0]  ctrl_b;
   logic [14:0] out_ctl;
   logic [11:0] period;
   logic [15:0] duty_reg [3];
   logic [7:0]  dead;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Ack masks a held request so it is taken once
   wire         req      = cyc_i & stb_i & ~ack_o;
   wire         wr       = req & we_i;
   wire  [11:0] idx      = adr_i[13:2];

   wire         hit_a    = idx == tpmpwm_pkg::IDX_CTRL_A;
   wire         hit_b    = idx == tpmpwm_pkg::IDX_CTRL_B;
   wire         hit_out  = idx == tpmpwm_pkg::IDX_OUT_CTL;
   wire         hit_cnt  = idx == tpmpwm_pkg::IDX_COUNT;
   wire         hit_prd  = idx == tpmpwm_pkg::IDX_PERIOD;
   wire         hit_u    = idx == tpmpwm_pkg::IDX_DUTY_U;
   wire         hit_v    = idx == tpmpwm_pkg::IDX_DUTY_V;
   wire         hit_w    = idx == tpmpwm_pkg::IDX_DUTY_W;
   wire         hit_dead = idx == tpmpwm_pkg::IDX_DEAD;

   wire  [2:0]  hit_duty = {hit_w, hit_v, hit_u};

   wire         wr_lo    = wr & sel_i[0];
   wire         wr_hi    = wr & sel_i[1];

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   wire         enable    = ctrl_a[tpmpwm_pkg::A_ENABLE];
   wire         tri_mode  = ctrl_a[tpmpwm_pkg::A_TRI];
   wire  [1:0]  intv      = ctrl_a[tpmpwm_pkg::A_INTV_LSB +: 2];
   wire         pol_up    = ctrl_a[tpmpwm_pkg::A_POL_UP];
   wire         pol_lo    = ctrl_a[tpmpwm_pkg::A_POL_LO];
   wire         duty_ind  = ctrl_a[tpmpwm_pkg::A_DUTY_IND];
   wire         half_int  = ctrl_a[tpmpwm_pkg::A_HALF_INT];

   wire         single_en = ctrl_b[tpmpwm_pkg::B_SINGLE_EN];
   wire         noncomp   = ctrl_b[tpmpwm_pkg::B_NONCOMP];
   wire  [1:0]  clk_sel   = ctrl_b[tpmpwm_pkg::B_CLK_LSB +: 2];

   wire         sync_prd  = out_ctl[tpmpwm_pkg::O_SYNC_PRD];
   wire  [1:0]  src_sel   = out_ctl[tpmpwm_pkg::O_SRC_LSB +: 2];

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_a  <= tpmpwm_pkg::RST_CTRL_A;
         ctrl_b  <= tpmpwm_pkg::RST_CTRL_B;
         out_ctl <= tpmpwm_pkg::RST_OUT_CTL;
         period  <= tpmpwm_pkg::RST_PERIOD;
         dead    <= tpmpwm_pkg::RST_DEAD;
      end else begin
         if (wr_lo && hit_a) ctrl_a <= dat_i[7:0];
         if (wr_lo && hit_b) ctrl_b <= dat_i[7:0];
         if (wr_lo && hit_dead) dead <= dat_i[7:0];

         if (wr_lo && hit_out) out_ctl[7:0] <= dat_i[7:0];
         if (wr_hi && hit_out) out_ctl[14:8] <= dat_i[14:8];

         if (wr_lo && hit_prd) period[7:0] <= dat_i[7:0];
         if (wr_hi && hit_prd) period[11:8] <= dat_i[11:8];
      end
   end

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   logic [2:0] div;
   wire  [2:0] div_mask = (3'h1 << clk_sel) - 3'h1;

   // Tick every 1, 2, 4 or 8 clocks
   wire        tick     = (div & div_mask) == 3'h0;

   // Cleared while off, so the first step comes at once
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable) div <= 3'h0;
      else                  div <= div + 3'h1;
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   logic [11:0] cnt;
   logic        dir_down;
   logic [11:0] act_period;

   // A shrunk period makes the counter wrap or turn at once
   wire         at_top  = cnt >= act_period;
   wire         at_bot  = cnt == 12'h000;
   wire         step    = enable & tick;
   // Period ends at sawtooth wrap or triangle valley
   wire         prd_evt = step & (tri_mode ? (dir_down & at_bot) : at_top);
   wire         half_evt = step & (tri_mode ? (~dir_down & at_top)
                                            : (cnt == (act_period >> 1)));

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable) begin
         cnt      <= 12'h000;
         dir_down <= 1'b0;
      end else if (tick) begin
         if (!tri_mode) begin
            cnt      <= at_top ? 12'h000 : cnt + 12'h001;
            dir_down <= 1'b0;
         end else if (!dir_down) begin
            if (at_top) begin
               dir_down <= 1'b1;
               cnt      <= cnt - 12'h001;
            end else begin
               cnt      <= cnt + 12'h001;
            end
         end else if (at_bot) begin
            dir_down <= 1'b0;
            cnt      <= cnt + 12'h001;
         end else begin
            cnt      <= cnt - 12'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Event interval
   // ----------------------------------------------------------------
   logic [2:0] prd_cnt;
   wire  [2:0] intv_mask = (3'h1 << intv) - 3'h1;

   // One event per 1, 2, 4 or 8 periods
   wire        intv_hit  = prd_evt & ((prd_cnt & intv_mask) == intv_mask);
   // Half-period events only with interval 00
   wire        half_hit  = half_int & (intv == 2'h0) & half_evt;

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable) prd_cnt <= 3'h0;
      else if (prd_evt)     prd_cnt <= prd_cnt + 3'h1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) pwm_event_o <= 1'b0;
      else       pwm_event_o <= intv_hit | half_hit;
   end

   // ----------------------------------------------------------------
   // Event pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] ev_s1;
   logic [2:0] ev_s2;
   logic [2:0] ev_s3;
   logic [2:0] ev_s4;

   // Edge counts only once stages two and three agree
   wire  [2:0] ev_rise = ev_s3 & ~ev_s4 & ev_s2;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_s1 <= 3'h0;
         ev_s2 <= 3'h0;
         ev_s3 <= 3'h0;
         ev_s4 <= 3'h0;
      end else begin
         ev_s1 <= {timer2_i, timer1_i, pos_detect_i};
         ev_s2 <= ev_s1;
         ev_s3 <= ev_s2;
         ev_s4 <= ev_s3;
      end
   end

   wire src_evt = (src_sel == tpmpwm_pkg::TPMPWM_SRC_ASYNC) ? 1'b1 :
                  (src_sel == tpmpwm_pkg::TPMPWM_SRC_POS)   ? ev_rise[0] :
                  (src_sel == tpmpwm_pkg::TPMPWM_SRC_TMR1)  ? ev_rise[1] :
                                                              ev_rise[2];
   wire load_set = sync_prd ? (prd_evt | ~enable) : 1'b1;
   // Event pulse lasts one cycle; keep it until the period end takes it
   logic evt_pend;
   wire  load_out = load_set & (src_evt | evt_pend);

   always_ff @(posedge clk_i) begin
      if (rst_i || load_out) evt_pend <= 1'b0;
      else if (src_evt)      evt_pend <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Active copies of settings
   // ----------------------------------------------------------------
   logic [2:0] act_sel;
   logic [5:0] act_lvl;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_period <= tpmpwm_pkg::RST_PERIOD;
         act_sel    <= 3'h0;
         act_lvl    <= 6'h00;
      end else begin
         if (load_set) act_period <= period;
         if (load_out) begin
            act_sel <= out_ctl[tpmpwm_pkg::O_SEL_LSB +: 3];
            act_lvl <= out_ctl[tpmpwm_pkg::O_LVL_LSB +: 6];
         end
      end
   end

   // ----------------------------------------------------------------
   // Per-phase duty, compare, dead time and polarity
   // ----------------------------------------------------------------
   wire [8:0] dead_cyc = 9'({dead, 1'b0}) * 9'(tpmpwm_pkg::DEAD_UNIT_CYC / 2);

   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_phase
         logic [15:0] act_duty;
         logic        prev;
         logic [8:0]  dt_cnt;

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               duty_reg[p] <= tpmpwm_pkg::RST_DUTY;
            end else begin
               // Bit 15 kept for single-side choice
               if (wr_lo && hit_duty[p]) duty_reg[p][7:0] <= dat_i[7:0];
               if (wr_hi && hit_duty[p]) duty_reg[p][15:8] <= {dat_i[15], 3'h0, dat_i[11:8]};
            end
         end

         // Shared U duty or own duty
         wire [15:0] duty_src = duty_ind ? duty_reg[p] : duty_reg[0];

         always_ff @(posedge clk_i) begin
            if (rst_i)         act_duty <= tpmpwm_pkg::RST_DUTY;
            else if (load_set) act_duty <= duty_src;
         end

         wire raw    = enable & (cnt < act_duty[11:0]);
         // Single-side only under the global enable
         wire single = single_en & act_duty[tpmpwm_pkg::D_SINGLE];

         // Both off for the dead time after each change
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               prev   <= 1'b0;
               dt_cnt <= 9'h000;
            end else if (raw != prev) begin
               prev   <= raw;
               dt_cnt <= dead_cyc;
            end else if (dt_cnt != 9'h000) begin
               dt_cnt <= dt_cnt - 9'h001;
            end
         end

         wire settled = dt_cnt == 9'h000;

         wire lower_pwm = ~prev & settled & enable & ~single & ~noncomp;
         wire upper_pwm = prev & settled;

         // PWM or fixed level per phase
         wire up_lvl = act_sel[p] ? upper_pwm : enable & act_lvl[2*p+1];
         wire lo_lvl = act_sel[p] ? lower_pwm : enable & act_lvl[2*p];

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               upper_o[p] <= 1'b1;
               lower_o[p] <= 1'b1;
            end else begin
               upper_o[p] <= pol_up ? up_lvl : ~up_lvl;
               lower_o[p] <= pol_lo ? lo_lvl : ~lo_lvl;
            end
         end
      end
   endgenerate

   assign pos_pattern_o = out_ctl[tpmpwm_pkg::O_PAT_LSB +: 3];

   // ----------------------------------------------------------------
   // Read mux and acknowledge
   // ----------------------------------------------------------------
   // Direction in bit 15
   wire [15:0] out_rd = {dir_down, out_ctl};

   // Unmapped offsets read zero; writes there are dropped
   // Live counter value
   wire [15:0] rd_mux = hit_a    ? {8'h00, ctrl_a} :
                        hit_b    ? {8'h00, ctrl_b} :
                        hit_out  ? out_rd :
                        hit_cnt  ? {4'h0, cnt} :
                        hit_prd  ? {4'h0, period} :
                        hit_u    ? duty_reg[0] :
                        hit_v    ? duty_reg[1] :
                        hit_w    ? duty_reg[2] :
                        hit_dead ? {8'h00, dead} : 16'h0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= req;
         if (req && !we_i) dat_o <= {16'h0000, rd_mux};
      end
   end

endmodule // tpmpwm_top

/* File: src/tpmpwm_pkg.sv */
/*
 * Constants for the three-phase motor PWM generator: register indices,
 * field positions, reset values and timing counts.
 * Assumes a 125 MHz source clock and a 32-bit classic Wishbone slave port.
 */
package tpmpwm_pkg;
   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [11:0] IDX_CTRL_A   = 12'hece;
   localparam logic [11:0] IDX_CTRL_B   = 12'hecf;
   localparam logic [11:0] IDX_OUT_CTL  = 12'hed2;
   localparam logic [11:0] IDX_COUNT    = 12'hed4;
   localparam logic [11:0] IDX_PERIOD   = 12'hed6;
   localparam logic [11:0] IDX_DUTY_U   = 12'hed8;
   localparam logic [11:0] IDX_DUTY_V   = 12'heda;
   localparam logic [11:0] IDX_DUTY_W   = 12'hedc;
   localparam logic [11:0] IDX_DEAD     = 12'hede;

   // ----------------------------------------------------------------
   // Control register A fields
   // ----------------------------------------------------------------
   localparam int A_HALF_INT  = 7;
   localparam int A_DUTY_IND  = 6;
   localparam int A_POL_UP    = 5;
   localparam int A_POL_LO    = 4;
   localparam int A_INTV_LSB  = 2;
   localparam int A_TRI       = 1;
   localparam int A_ENABLE    = 0;

   // ----------------------------------------------------------------
   // Control register B fields
   // ----------------------------------------------------------------
   localparam int B_SINGLE_EN = 7;
   localparam int B_NONCOMP   = 2;
   localparam int B_CLK_LSB   = 0;

   // ----------------------------------------------------------------
   // Phase output control fields
   // ----------------------------------------------------------------
   localparam int O_DIR       = 15;
   localparam int O_PAT_LSB   = 12;
   localparam int O_SYNC_PRD  = 11;
   localparam int O_SEL_LSB   = 8;
   localparam int O_SRC_LSB   = 6;
   localparam int O_LVL_LSB   = 0;

   // Duty register single-side bit
   localparam int D_SINGLE    = 15;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_CTRL_A  = 8'h00;
   localparam logic [7:0]  RST_CTRL_B  = 8'h00;
   localparam logic [14:0] RST_OUT_CTL = 15'h0000;
   localparam logic [11:0] RST_PERIOD  = 12'hfff;
   localparam logic [15:0] RST_DUTY    = 16'h0000;
   localparam logic [7:0]  RST_DEAD    = 8'h00;

   // ----------------------------------------------------------------
   // Timing: dead time unit is two source-clock periods
   // ----------------------------------------------------------------
   localparam int DEAD_UNIT_CYC = 2;

   // Output update sources
   typedef enum logic [1:0] {
      TPMPWM_SRC_ASYNC = 2'h0,
      TPMPWM_SRC_POS   = 2'h1,
      TPMPWM_SRC_TMR1  = 2'h2,
      TPMPWM_SRC_TMR2  = 2'h3
   } tpmpwm_src_t;
endpackage

/* File: verification/tpmpwm_checker.sv */
/*
 * Port checker for tpmpwm_top: bus timing, read data, event pulse, idle outputs.
 * Assumes one clock, synchronous active-high reset; bound to every tpmpwm_top.
 */
`timescale 1ns/1ps
module tpmpwm_checker (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [13:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   // Outputs
   input  wire logic [2:0]  upper_o,
   input  wire logic [2:0]  lower_o,
   input  wire logic        pwm_event_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------
   // Shadow of enable and polarity
   // ------------------------------------------------------------
   wire        take = cyc_i && stb_i && !ack_o;
   wire [11:0] idx  = adr_i[13:2];
   wire        wr_a = take && we_i && sel_i[0] && (idx == tpmpwm_pkg::IDX_CTRL_A);
   logic       en_sh;
   logic       pu_sh;
   logic       pl_sh;
   logic [1:0] quiet;
   // Quiet counter leaves margin for the registered outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {en_sh, pu_sh, pl_sh} <= 3'h0;
         quiet <= 2'h3;
      end else if (wr_a) begin
         {en_sh, pu_sh, pl_sh} <= {dat_i[0], dat_i[5], dat_i[4]};
         quiet <= 2'h0;
      end else if (quiet != 2'h3) begin
         quiet <= quiet + 2'h1;
      end
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_ack_follows_req: assert property (take |=> ack_o)
      else $error("ack missing after request");
   a_ack_one_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_rdata_holds: assert property (!(take && !we_i) |=> $stable(dat_o))
      else $error("read data changed without read");
   a_rdata_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_unmapped_reads_zero: assert property
      (take && !we_i && idx < tpmpwm_pkg::IDX_CTRL_A |=> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_event_one_cycle: assert property (pwm_event_o |=> !pwm_event_o)
      else $error("event pulse longer than one cycle");
   a_idle_when_off: assert property (!en_sh && quiet == 2'h3 |->
      upper_o == {3{!pu_sh}} && lower_o == {3{!pl_sh}})
      else $error("outputs not idle while disabled");
   c_write: cover property (take && we_i);
   c_read: cover property (take && !we_i);
   c_event: cover property (pwm_event_o);
endmodule // tpmpwm_checker

bind tpmpwm_top tpmpwm_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .upper_o(upper_o), .lower_o(lower_o),
   .pwm_event_o(pwm_event_o));

/* File: verification/tpmpwm_gate_model.sv */
/*
 * Inverter gate stage model: counts cycles where both switches of a leg conduct.
 * Assumes the bench tells it the programmed polarity.
 */
`timescale 1ns/1ps
module tpmpwm_gate_model (
   // Clock
   input  wire logic       clk_i,
   // Gate lines and polarity
   input  wire logic [2:0] upper_i,
   input  wire logic [2:0] lower_i,
   input  wire logic       pol_up_i,
   input  wire logic       pol_lo_i,
   // Shoot-through count
   output int              shoot_o
);
   // Both switches on shorts the supply
   wire [2:0] up_on = pol_up_i ? upper_i : ~upper_i;
   wire [2:0] lo_on = pol_lo_i ? lower_i : ~lower_i;
   initial shoot_o = 0;
   always @(posedge clk_i) begin
      if (|(up_on & lo_on)) begin
         shoot_o <= shoot_o + 1;
      end
   end
endmodule // tpmpwm_gate_model

/* File: verification/test_tpmpwm_top.sv */
/*
 * Self-checking bench for tpmpwm_top: registers, rates, waveforms, dead time.
 * Assumes the checker is bound and the gate model sits on the outputs.
 */
`timescale 1ns/1ps
module test_tpmpwm_top;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pwm_event_o, pol_up, pol_lo;
   logic [13:0] adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o;
   logic [2:0]  upper_o, lower_o, pos_pattern_o, ev;
   int          miscompares, samples_checked, shoot, cu[3], cl[3], g, sh0;
   tpmpwm_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .pos_detect_i(ev[0]), .timer1_i(ev[1]), .timer2_i(ev[2]),
      .upper_o(upper_o), .lower_o(lower_o), .pos_pattern_o(pos_pattern_o),
      .pwm_event_o(pwm_event_o));
   tpmpwm_gate_model gate_u (.clk_i(clk_i), .upper_i(upper_o), .lower_i(lower_o),
      .pol_up_i(pol_up), .pol_lo_i(pol_lo), .shoot_o(shoot));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
         miscompares++;
      end
   endtask
   task automatic wb(logic w, logic [11:0] idx, logic [15:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i} <= {2'b11, w};
      adr_i <= {idx, 2'b00};
      dat_i <= {16'h0000, wd};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      rd = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
      chk("bus ack", 1'b1, ack_o);
   endtask
   task automatic wr(logic [11:0] idx, logic [15:0] wd);
      logic [31:0] rd;
      wb(1'b1, idx, wd, rd);
   endtask
   task automatic rchk(string nm, logic [11:0] idx, logic [31:0] e);
      logic [31:0] rd;
      wb(1'b0, idx, 16'h0000, rd);
      chk(nm, e, rd);
   endtask
   // Period fixed at the legal minimum; enable written last
   task automatic cfg(logic [7:0] a, b, logic [15:0] o, du, dv, dw, logic [7:0] dt);
      wr(tpmpwm_pkg::IDX_CTRL_A, 16'h0000);
      wr(tpmpwm_pkg::IDX_CTRL_B, {8'h00, b});
      wr(tpmpwm_pkg::IDX_OUT_CTL, o);
      wr(tpmpwm_pkg::IDX_PERIOD, 16'h0010);
      wr(tpmpwm_pkg::IDX_DUTY_U, du);
      wr(tpmpwm_pkg::IDX_DUTY_V, dv);
      wr(tpmpwm_pkg::IDX_DUTY_W, dw);
      wr(tpmpwm_pkg::IDX_DEAD, {8'h00, dt});
      wr(tpmpwm_pkg::IDX_CTRL_A, {8'h00, a});
      {pol_up, pol_lo} = {a[5], a[4]};
   endtask
   // Second gap is measured; the first may straddle the setup
   task automatic gap();
      repeat (2) begin
         g = 0;
         do begin
            @(posedge clk_i);
            g++;
         end while (pwm_event_o !== 1'b1 && g < 3000);
      end
   endtask
   // One period of 136 clocks: period 0x10, divide by 8
   task automatic run(logic [7:0] a, b, logic [15:0] o, du, dv, dw, logic [7:0] dt);
      cfg(a, b, o, du, dv, dw, dt);
      gap();
      cu = '{0, 0, 0};
      cl = '{0, 0, 0};
      sh0 = shoot;
      repeat (136) begin
         @(posedge clk_i);
         for (int p = 0; p < 3; p++) begin
            cu[p] += int'(upper_o[p] === pol_up);
            cl[p] += int'(lower_o[p] === pol_lo);
         end
      end
   endtask
   task automatic cmp3(string nm, int u0, u1, u2, l0, l1, l2);
      chk({nm, " upper U"}, u0, cu[0]);
      chk({nm, " upper V"}, u1, cu[1]);
      chk({nm, " upper W"}, u2, cu[2]);
      chk({nm, " lower U"}, l0, cl[0]);
      chk({nm, " lower V"}, l1, cl[1]);
      chk({nm, " lower W"}, l2, cl[2]);
      $display("test %s done", nm);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rchk("ctrl a reset", tpmpwm_pkg::IDX_CTRL_A, 32'h0);
      rchk("period reset", tpmpwm_pkg::IDX_PERIOD, 32'hfff);
      rchk("unmapped", 12'h000, 32'h0);
      wr(tpmpwm_pkg::IDX_OUT_CTL, 16'h7000);
      rchk("pattern", tpmpwm_pkg::IDX_OUT_CTL, 32'h7000);
      chk("pattern pins", 3'h7, pos_pattern_o);
      wr(tpmpwm_pkg::IDX_DUTY_V, 16'h8abc);
      rchk("duty v", tpmpwm_pkg::IDX_DUTY_V, 32'h8abc);
      wr(tpmpwm_pkg::IDX_COUNT, 16'h0abc);
      rchk("count read only", tpmpwm_pkg::IDX_COUNT, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_rates();
      logic [31:0] rd;
      logic        up, dn;
      for (int d = 0; d < 4; d++) begin
         cfg(8'h01, 8'(d), 16'h0700, 16'h8, 16'h0, 16'h0, 8'h0);
         gap();
         chk("divider gap", 17 << d, g);
      end
      for (int k = 0; k < 4; k++) begin
         cfg(8'(1 + 4 * k), 8'h00, 16'h0700, 16'h8, 16'h0, 16'h0, 8'h0);
         gap();
         chk("interval gap", 17 << k, g);
      end
      cfg(8'h83, 8'h00, 16'h0700, 16'h8, 16'h0, 16'h0, 8'h0);
      gap();
      chk("half period gap", 16, g);
      cfg(8'h03, 8'h00, 16'h0700, 16'h8, 16'h0, 16'h0, 8'h0);
      gap();
      chk("triangle gap", 32, g);
      {up, dn} = 2'b00;
      repeat (20) begin
         wb(1'b0, tpmpwm_pkg::IDX_OUT_CTL, 16'h0, rd);
         {up, dn} = {up | !rd[15], dn | rd[15]};
      end
      chk("direction seen", 2'b11, {up, dn});
      wb(1'b0, tpmpwm_pkg::IDX_COUNT, 16'h0, rd);
      chk("count range", 1'b1, rd <= 32'h10);
      $display("test rates done");
   endtask
   task automatic t_wave();
      run(8'h31, 8'h03, 16'h0700, 16'h8, 16'h0, 16'h0, 8'h0);
      cmp3("common duty", 64, 64, 64, 72, 72, 72);
      run(8'h31, 8'h03, 16'h0700, 16'h8, 16'h0, 16'h0, 8'h4);
      cmp3("dead time", 56, 56, 56, 64, 64, 64);
      chk("shoot through", 0, shoot - sh0);
      run(8'h01, 8'h03, 16'h0700, 16'h8, 16'h0, 16'h0, 8'h4);
      cmp3("active low", 56, 56, 56, 64, 64, 64);
      run(8'h71, 8'h03, 16'h0700, 16'h8, 16'h4, 16'hc, 8'h0);
      cmp3("own duty", 64, 32, 96, 72, 104, 40);
      run(8'h31, 8'h07, 16'h0700, 16'h8, 16'h0, 16'h0, 8'h0);
      cmp3("non complementary", 64, 64, 64, 0, 0, 0);
      run(8'h71, 8'h83, 16'h0700, 16'h8008, 16'h8, 16'h8, 8'h0);
      cmp3("single side", 64, 64, 64, 0, 72, 72);
      run(8'h71, 8'h03, 16'h0700, 16'h8008, 16'h8, 16'h8, 8'h0);
      cmp3("single side off", 64, 64, 64, 72, 72, 72);
      run(8'h31, 8'h03, 16'h0006, 16'h8, 16'h0, 16'h0, 8'h0);
      cmp3("fixed level", 136, 0, 0, 0, 136, 0);
   endtask
   // Timer 1 source: a position pulse must not load, a timer 1 pulse must
   task automatic t_sync();
      for (int s = 0; s < 3; s++) begin
         ev <= 3'(s);
         repeat (8) @(posedge clk_i);
         ev <= 3'h0;
         run(8'h31, 8'h03, 16'h0882, 16'h8, 16'h0, 16'h0, 8'h0);
         cmp3($sformatf("source %0d", s), 136, 0, 0, 0, 136 * (s < 2), 0);
      end
   endtask
   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 3'b000, 14'h0, 4'h3, 32'h0};
      {pol_up, pol_lo, ev, miscompares, samples_checked} = '0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_rates();
      t_wave();
      t_sync();
      report_and_stop();
   end
   // Run needs about 6k clocks
   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end
endmodule // test_tpmpwm_top
